// ===== aors_consts.vh
// Constants for the axis origin return sequencer
`ifndef AORS_CONSTS_VH
`define AORS_CONSTS_VH

// Command codes
`define AORS_CMD_RET_PLUS 8'h10
`define AORS_CMD_RET_MINUS 8'h18
`define AORS_CMD_ESC_PLUS 8'h12
`define AORS_CMD_ESC_MINUS 8'h1A

// Homing methods handled here
`define AORS_METH_LIM_IDX 4'h8
`define AORS_METH_ORG_ZERO 4'h9
`define AORS_METH_ORG_IDX_ZERO 4'hA
`define AORS_METH_ORG_REV_IDX_ZERO 4'hB
`define AORS_METH_LIM_IDX_ZERO 4'hC

// Method decode vector bit positions
`define AORS_MD_VALID 7
`define AORS_MD_REF_LIMIT 6
`define AORS_MD_REF_STOP 5
`define AORS_MD_HAS_IDX 4
`define AORS_MD_IDX_REV 3
`define AORS_MD_IDX_DECEL 2
`define AORS_MD_HAS_ZERO 1

// Deviation-clear pulse width
`define AORS_CLK_MHZ 125
`define AORS_ERC_TIME_NS 1000
`define AORS_ERC_CYCLES ((`AORS_ERC_TIME_NS * `AORS_CLK_MHZ) / 1000)

// Reset values
`define AORS_IDX_RESET 4'h0
`define AORS_ERC_CNT_RESET 8'h00

`endif

// ===== aors_edge_bank.v
// Rising-edge detectors for the sensor inputs
`timescale 1ns/1ps
module aors_edge_bank #(
	parameter WIDTH = 4
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Levels in, active high
	input wire [WIDTH-1:0] level_in,
	// Registered inactive-to-active pulses
	output wire [WIDTH-1:0] rise_out
);

	reg [WIDTH-1:0] last_reg;
	reg [WIDTH-1:0] rise_reg;
	reg armed_reg;

	// No false edge from a level already high at reset
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			armed_reg <= 1'b0;
		end else begin
			armed_reg <= 1'b1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_edge
			always @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					last_reg[gi] <= 1'b0;
					rise_reg[gi] <= 1'b0;
				end else begin
					last_reg[gi] <= level_in[gi];
					rise_reg[gi] <= level_in[gi] & ~last_reg[gi] &
						armed_reg;
				end
			end
		end
	endgenerate

	assign rise_out = rise_reg;

endmodule // aors_edge_bank

// ===== aors_motor_model.sv
// Motor driver, pulse generator and sensor model
`timescale 1ns/1ps
module aors_motor_model #(
	parameter ORG_LO = -3,
	parameter ORG_HI = 5,
	parameter LIM = 20
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Generator control
	input wire move_run_reg,
	input wire move_dir_minus_reg,
	input wire move_decel_reg,
	input wire [3:0] counter_clear_reg,
	// Status and sensors
	output reg move_idle,
	output reg pulse_out,
	output wire counter_two_zero,
	output wire origin_sensor,
	output wire end_limit_pos,
	output wire end_limit_neg,
	output wire encoder_index
);
	integer pos;
	integer zero_at;
	reg [1:0] div;
	reg [2:0] left;
	assign counter_two_zero = pos == zero_at;
	assign origin_sensor = pos >= ORG_LO && pos <= ORG_HI;
	assign end_limit_pos = pos >= LIM;
	assign end_limit_neg = pos <= -LIM;
	assign encoder_index = pos % 8 == 0;
	// One pulse every four cycles, four more once decelerating
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pos <= 0;
			zero_at <= 0;
			div <= 2'h0;
			left <= 3'h4;
			move_idle <= 1'b1;
			pulse_out <= 1'b0;
		end else begin
			pulse_out <= 1'b0;
			move_idle <= !move_run_reg || left == 3'h0;
			if (!move_decel_reg)
				left <= 3'h4;
			if (counter_clear_reg[1])
				zero_at <= pos;
			div <= 2'h0;
			if (move_run_reg && left != 3'h0) begin
				div <= div + 2'h1;
				if (div == 2'h3) begin
					pulse_out <= 1'b1;
					pos <= move_dir_minus_reg ? pos - 1 : pos + 1;
					if (move_decel_reg)
						left <= left - 3'h1;
				end
			end
		end
	end
endmodule // aors_motor_model

// ===== aors_sequencer.v
// Axis origin return sequencer: homing methods 8 to 12 and origin escape
//
// Operation
// - Method 8: limit stop, reverse, count index edges, decelerate past origin.
// - Limit used as reference with decel stop: no abnormal stop, no error.
// - Reference limit with immediate stop and clear enabled: halt, deviation clear, then reverse.
// - Clear each selected counter at the moment origin is detected.
// - Deviation clear pulse when homing stops at origin, if enabled.
// - Method 9: decel stop on origin edge, reverse until counter two zero.
// - Method 10: pass origin at speed, count index, stop, return to zero.
// - Method 11: stop on origin, reverse, count index, stop, travel to zero.
// - Method 12: limit-reverse-index, immediate stop at count, back to zero.
// - Minus origin return mirrors plus one, direction and limit swapped.
// - Plus escape runs while origin active, one more pulse, then completes.
// - Escape started with origin inactive completes without any pulse.
// - Minus escape mirrors plus escape with direction reversed.
// - Four-bit index setting loads down-counter; zero means one edge.
// - Limit handling bit: zero immediate stop, one decelerating stop.
`timescale 1ns/1ps
`include "aors_consts.vh"
module aors_sequencer #(
	parameter ERC_CYCLES = `AORS_ERC_CYCLES
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Command
	input wire cmd_start,
	input wire [7:0] cmd_code,
	input wire cmd_accel,
	// Environment settings
	input wire [3:0] homing_method_select,
	input wire [3:0] index_count_setting,
	input wire limit_stop_method,
	input wire clear_out_on_limit,
	input wire clear_out_on_origin,
	input wire [3:0] counter_clear_on_origin,
	// Sensors, logic-selected and filtered, active high
	input wire origin_sensor,
	input wire end_limit_pos,
	input wire end_limit_neg,
	input wire encoder_index,
	// Pulse generator status
	input wire move_idle,
	input wire pulse_out,
	input wire counter_two_zero,
	// Pulse generator control
	output reg move_run_reg,
	output reg move_dir_minus_reg,
	output reg move_decel_reg,
	// Counter and servo outputs
	output reg [3:0] counter_clear_reg,
	output reg deviation_clear_out_reg,
	// Status
	output reg busy_reg,
	output reg op_done_reg,
	output reg abnormal_stop_reg
);

	localparam S_IDLE = 4'h0;
	localparam S_SEEK = 4'h1;
	localparam S_STOP = 4'h2;
	localparam S_ERC = 4'h3;
	localparam S_LAUNCH = 4'h4;
	localparam S_IDX = 4'h5;
	localparam S_ZERO = 4'h6;
	localparam S_ESC = 4'h7;
	localparam S_ESC_LAST = 4'h8;
	localparam S_DONE = 4'h9;

	////////////////////////////////////////////////////////////////////
	// Method decode

	function [7:0] meth_decode;
		input [3:0] m;
		begin
			case (m)
				`AORS_METH_LIM_IDX: meth_decode = 8'hDC;
				`AORS_METH_ORG_ZERO: meth_decode = 8'hA2;
				`AORS_METH_ORG_IDX_ZERO: meth_decode = 8'h96;
				`AORS_METH_ORG_REV_IDX_ZERO: meth_decode = 8'hBE;
				`AORS_METH_LIM_IDX_ZERO: meth_decode = 8'hDA;
				default: meth_decode = 8'h00;
			endcase
		end
	endfunction

	function is_minus_cmd;
		input [7:0] c;
		begin
			is_minus_cmd = (c == `AORS_CMD_RET_MINUS) ||
				(c == `AORS_CMD_ESC_MINUS);
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Sensor edges

	wire [3:0] rise;
	aors_edge_bank #(
		.WIDTH(4)
	) u_edges (
		.clk(clk),
		.rst_b(rst_b),
		.level_in({encoder_index, end_limit_neg, end_limit_pos,
			origin_sensor}),
		.rise_out(rise)
	);

	wire org_rise = rise[0];
	wire lim_fwd_rise = move_dir_minus_reg ? rise[2] : rise[1];
	wire idx_rise = rise[3];

	////////////////////////////////////////////////////////////////////
	// Sequencer

	reg [3:0] state_reg;
	reg [3:0] after_reg;
	reg [7:0] md_reg;
	reg flip_reg;
	reg erc_pend_reg;
	reg [3:0] idx_cnt_reg;
	reg [7:0] erc_cnt_reg;

	wire [7:0] md_now = meth_decode(homing_method_select);
	wire accel_stop = cmd_accel & md_reg[`AORS_MD_IDX_DECEL];

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= S_IDLE;
			after_reg <= S_IDLE;
			md_reg <= 8'h00;
			flip_reg <= 1'b0;
			erc_pend_reg <= 1'b0;
			idx_cnt_reg <= `AORS_IDX_RESET;
			erc_cnt_reg <= `AORS_ERC_CNT_RESET;
			move_run_reg <= 1'b0;
			move_dir_minus_reg <= 1'b0;
			move_decel_reg <= 1'b0;
			counter_clear_reg <= 4'h0;
			deviation_clear_out_reg <= 1'b0;
			busy_reg <= 1'b0;
			op_done_reg <= 1'b0;
			abnormal_stop_reg <= 1'b0;
		end else begin
			counter_clear_reg <= 4'h0;
			op_done_reg <= 1'b0;
			abnormal_stop_reg <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (cmd_start) begin
						busy_reg <= 1'b1;
						md_reg <= md_now;
						move_dir_minus_reg <= is_minus_cmd(cmd_code);
						move_decel_reg <= 1'b0;
						if (cmd_code == `AORS_CMD_ESC_PLUS ||
							cmd_code == `AORS_CMD_ESC_MINUS) begin
							if (origin_sensor) begin
								move_run_reg <= 1'b1;
								state_reg <= S_ESC;
							end else begin
								state_reg <= S_DONE;
							end
						end else if ((cmd_code == `AORS_CMD_RET_PLUS ||
							cmd_code == `AORS_CMD_RET_MINUS) &&
							md_now[`AORS_MD_VALID]) begin
							move_run_reg <= 1'b1;
							state_reg <= S_SEEK;
						end else begin
							state_reg <= S_DONE;
						end
					end
				end
				S_SEEK: begin
					if (md_reg[`AORS_MD_REF_LIMIT] && lim_fwd_rise) begin
						flip_reg <= 1'b1;
						after_reg <= S_IDX;
						state_reg <= S_STOP;
						if (limit_stop_method) begin
							move_decel_reg <= 1'b1;
							erc_pend_reg <= 1'b0;
						end else begin
							move_run_reg <= 1'b0;
							erc_pend_reg <= clear_out_on_limit;
						end
					end else if (!md_reg[`AORS_MD_REF_LIMIT] &&
						lim_fwd_rise) begin
						abnormal_stop_reg <= 1'b1;
						move_run_reg <= limit_stop_method;
						move_decel_reg <= limit_stop_method;
						erc_pend_reg <= 1'b0;
						after_reg <= S_DONE;
						flip_reg <= 1'b0;
						state_reg <= S_STOP;
					end else if (org_rise && !md_reg[`AORS_MD_REF_LIMIT]) begin
						if (!md_reg[`AORS_MD_HAS_IDX]) begin
							counter_clear_reg <= counter_clear_on_origin;
							move_decel_reg <= 1'b1;
							erc_pend_reg <= clear_out_on_origin;
							after_reg <= S_ZERO;
							flip_reg <= 1'b1;
							state_reg <= S_STOP;
						end else if (!md_reg[`AORS_MD_IDX_REV]) begin
							idx_cnt_reg <= index_count_setting;
							state_reg <= S_IDX;
						end else begin
							move_decel_reg <= 1'b1;
							erc_pend_reg <= 1'b0;
							after_reg <= S_IDX;
							flip_reg <= 1'b1;
							state_reg <= S_STOP;
						end
					end
				end
				S_STOP: begin
					if (move_idle) begin
						move_run_reg <= 1'b0;
						move_decel_reg <= 1'b0;
						if (erc_pend_reg) begin
							erc_cnt_reg <= ERC_CYCLES[7:0];
							deviation_clear_out_reg <= 1'b1;
							state_reg <= S_ERC;
						end else begin
							state_reg <= S_LAUNCH;
						end
					end
				end
				S_ERC: begin
					if (erc_cnt_reg == 8'h01) begin
						deviation_clear_out_reg <= 1'b0;
						erc_pend_reg <= 1'b0;
						state_reg <= S_LAUNCH;
					end else begin
						erc_cnt_reg <= erc_cnt_reg - 8'h01;
					end
				end
				S_LAUNCH: begin
					if (flip_reg) begin
						move_dir_minus_reg <= ~move_dir_minus_reg;
					end
					flip_reg <= 1'b0;
					idx_cnt_reg <= index_count_setting;
					move_run_reg <= (after_reg != S_DONE);
					state_reg <= after_reg;
				end
				S_IDX: begin
					if (lim_fwd_rise) begin
						abnormal_stop_reg <= 1'b1;
						move_run_reg <= limit_stop_method;
						move_decel_reg <= limit_stop_method;
						after_reg <= S_DONE;
						state_reg <= S_STOP;
					end else if (idx_rise) begin
						if (idx_cnt_reg == 4'h0) begin
							counter_clear_reg <= counter_clear_on_origin;
							move_decel_reg <= accel_stop;
							move_run_reg <= accel_stop;
							erc_pend_reg <= clear_out_on_origin;
							after_reg <= md_reg[`AORS_MD_HAS_ZERO] ?
								S_ZERO : S_DONE;
							flip_reg <= md_reg[`AORS_MD_HAS_ZERO];
							state_reg <= S_STOP;
						end else begin
							idx_cnt_reg <= idx_cnt_reg - 4'h1;
						end
					end
				end
				S_ZERO: begin
					if (lim_fwd_rise) begin
						abnormal_stop_reg <= 1'b1;
						move_run_reg <= limit_stop_method;
						move_decel_reg <= limit_stop_method;
						after_reg <= S_DONE;
						erc_pend_reg <= 1'b0;
						state_reg <= S_STOP;
					end else if (counter_two_zero) begin
						move_run_reg <= 1'b0;
						after_reg <= S_DONE;
						erc_pend_reg <= 1'b0;
						state_reg <= S_STOP;
					end
				end
				S_ESC: begin
					if (!origin_sensor) begin
						state_reg <= S_ESC_LAST;
					end
				end
				S_ESC_LAST: begin
					if (pulse_out) begin
						move_run_reg <= 1'b0;
						state_reg <= S_DONE;
					end
				end
				S_DONE: begin
					move_run_reg <= 1'b0;
					move_decel_reg <= 1'b0;
					busy_reg <= 1'b0;
					op_done_reg <= 1'b1;
					state_reg <= S_IDLE;
				end
				default: begin
					move_run_reg <= 1'b0;
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

endmodule // aors_sequencer

// ===== aors_sequencer_assertions.sv
// Concurrent checks of the origin return sequencer
`timescale 1ns/1ps
module aors_sequencer_assertions #(
	parameter ERC_CYCLES = 125
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Command, settings and sensors
	input wire cmd_start,
	input wire [7:0] cmd_code,
	input wire [3:0] homing_method_select,
	input wire limit_stop_method,
	input wire clear_out_on_limit,
	input wire [3:0] counter_clear_on_origin,
	input wire origin_sensor,
	input wire end_limit_pos,
	// Sequencer outputs
	input wire move_run_reg,
	input wire move_dir_minus_reg,
	input wire move_decel_reg,
	input wire [3:0] counter_clear_reg,
	input wire deviation_clear_out_reg,
	input wire busy_reg,
	input wire op_done_reg,
	input wire abnormal_stop_reg
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	reg [7:0] high_cnt;
	wire minus_code = cmd_code[3];
	wire esc_go = cmd_start && !busy_reg && cmd_code[7:4] == 4'h1 &&
		cmd_code[2:0] == 3'h2;
	wire lim_ref = homing_method_select[3] &&
		homing_method_select[1:0] == 2'h0;
	////////////////////////////////////////////////////////////////////////
	// High time of the deviation clear
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			high_cnt <= 8'h00;
		else if (deviation_clear_out_reg)
			high_cnt <= high_cnt + 8'h01;
		else
			high_cnt <= 8'h00;
	end
	sequence s_halted;
		##[1:3] (!move_run_reg && !move_decel_reg);
	endsequence
	sequence s_clear_out;
		##[0:6] deviation_clear_out_reg;
	endsequence
	////////////////////////////////////////////////////////////////////////
	a_erc_width: assert property ( // pulse width
		$fell(deviation_clear_out_reg) |-> high_cnt == ERC_CYCLES)
		else $error("deviation clear width wrong");
	a_limit_halt: assert property ( // immediate halt
		busy_reg && lim_ref && !limit_stop_method && clear_out_on_limit &&
		!move_dir_minus_reg && $rose(end_limit_pos) |->
		s_halted ##1 s_clear_out) else $error("limit halt wrong");
	a_ref_no_abn: assert property ( // reference limit
		abnormal_stop_reg |-> !(lim_ref && limit_stop_method &&
		end_limit_pos && !move_dir_minus_reg)) else $error("abnormal stop");
	a_clear_mask: assert property ( // selected counters
		|counter_clear_reg |-> counter_clear_reg == counter_clear_on_origin)
		else $error("counter clear mask wrong");
	a_clear_pulse: assert property ( // single pulse
		|counter_clear_reg |=> counter_clear_reg == 4'h0)
		else $error("counter clear too long");
	a_origin_decel: assert property ( // origin stop
		busy_reg && homing_method_select == 4'h9 && move_run_reg &&
		!move_dir_minus_reg && !move_decel_reg && $rose(origin_sensor) |->
		##[1:2] (move_decel_reg && |counter_clear_reg))
		else $error("no stop at origin");
	a_escape_idle: assert property ( // no motion
		esc_go && !origin_sensor |=> (busy_reg && !move_run_reg) ##1
		(op_done_reg && !move_run_reg)) else $error("escape moved");
	a_escape_dir: assert property ( // direction
		esc_go && origin_sensor |=> move_run_reg &&
		move_dir_minus_reg == $past(minus_code)) else $error("escape dir");
endmodule // aors_sequencer_assertions

bind aors_sequencer aors_sequencer_assertions #(
	.ERC_CYCLES(ERC_CYCLES)
) u_chk (
	.clk, .rst_b, .cmd_start, .cmd_code, .homing_method_select,
	.limit_stop_method, .clear_out_on_limit, .counter_clear_on_origin,
	.origin_sensor, .end_limit_pos, .move_run_reg, .move_dir_minus_reg,
	.move_decel_reg, .counter_clear_reg, .deviation_clear_out_reg,
	.busy_reg, .op_done_reg, .abnormal_stop_reg
);

// ===== axis_origin_return_sequencer_test.sv
// Self-checking bench of the origin return sequencer
`timescale 1ns/1ps
`include "aors_consts.vh"
`define CHK(nm, e, g) begin n_compared = n_compared + 1; \
	if ((g) !== (e)) begin n_fail = n_fail + 1; \
	$display("MISMATCH %s expected %0d seen %0d", nm, e, g); end end
module axis_origin_return_sequencer_test;
	reg clk;
	reg rst_b = 1'b0;
	reg cmd_start = 1'b0;
	reg [7:0] cmd_code = 8'h00;
	reg cmd_accel = 1'b0;
	reg [3:0] homing_method_select = 4'h0;
	reg [3:0] index_count_setting = 4'h0;
	reg limit_stop_method = 1'b1;
	reg clear_out_on_limit = 1'b0;
	reg clear_out_on_origin = 1'b1;
	reg [3:0] counter_clear_on_origin = 4'hF;
	reg erc_q = 1'b0;
	wire move_idle, pulse_out, counter_two_zero, origin_sensor;
	wire end_limit_pos, end_limit_neg, encoder_index, move_run_reg;
	wire move_dir_minus_reg, move_decel_reg, deviation_clear_out_reg;
	wire busy_reg, op_done_reg, abnormal_stop_reg;
	wire [3:0] counter_clear_reg;
	integer n_fail = 0;
	integer n_compared = 0;
	integer n_erc = 0;
	integer n_abn = 0;
	aors_sequencer #(
		.ERC_CYCLES(2)
	) DUT (
		.clk, .rst_b, .cmd_start, .cmd_code, .cmd_accel,
		.homing_method_select, .index_count_setting, .limit_stop_method,
		.clear_out_on_limit, .clear_out_on_origin, .counter_clear_on_origin,
		.origin_sensor, .end_limit_pos, .end_limit_neg, .encoder_index,
		.move_idle, .pulse_out, .counter_two_zero, .move_run_reg,
		.move_dir_minus_reg, .move_decel_reg, .counter_clear_reg,
		.deviation_clear_out_reg, .busy_reg, .op_done_reg, .abnormal_stop_reg
	);
	aors_motor_model MDL (
		.clk, .rst_b, .move_run_reg, .move_dir_minus_reg, .move_decel_reg,
		.counter_clear_reg, .move_idle, .pulse_out, .counter_two_zero,
		.origin_sensor, .end_limit_pos, .end_limit_neg, .encoder_index
	);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Counts clear pulses and abnormal stops
	always @(negedge clk) begin
		if (deviation_clear_out_reg === 1'b1 && !erc_q)
			n_erc = n_erc + 1;
		erc_q = deviation_clear_out_reg;
		if (abnormal_stop_reg === 1'b1)
			n_abn = n_abn + 1;
	end
	////////////////////////////////////////////////////////////////////////
	task finish_test;
		begin
			$display("compared %0d mismatches %0d", n_compared, n_fail);
			if (n_fail == 0 && n_compared > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task go(input [7:0] code, input [3:0] m);
		integer i;
		begin
			@(negedge clk);
			cmd_code = code;
			homing_method_select = m;
			cmd_accel = !code[1];
			cmd_start = 1'b1;
			@(negedge clk);
			cmd_start = 1'b0;
			i = 0;
			while (op_done_reg !== 1'b1 && i < 5000) begin
				@(negedge clk);
				i = i + 1;
			end
			$display("test cmd %h method %h done", code, m);
			if (i == 5000) begin
				n_fail = n_fail + 1;
				finish_test;
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		go(`AORS_CMD_ESC_MINUS, 4'h0);
		`CHK("minus escape", -5, MDL.pos) // minus escape
		go(`AORS_CMD_ESC_PLUS, 4'h0);
		`CHK("idle escape", -5, MDL.pos) // no pulse
		go(`AORS_CMD_RET_PLUS, 4'h9);
		`CHK("m9 origin", -3, MDL.zero_at) // clear at origin
		`CHK("m9 end", -3, MDL.pos) // zero return
		`CHK("m9 clear out", 1, n_erc) // one clear pulse
		go(`AORS_CMD_ESC_PLUS, 4'h0);
		`CHK("plus escape", 7, MDL.pos) // one extra pulse
		go(`AORS_CMD_RET_MINUS, 4'hA);
		`CHK("m10 origin", 0, MDL.zero_at) // mirrored return
		`CHK("m10 end", 0, MDL.pos) // index then zero
		index_count_setting = 4'h1;
		go(`AORS_CMD_RET_PLUS, 4'h8);
		`CHK("m8 origin", 8, MDL.zero_at) // second index
		`CHK("m8 abnormal", 0, n_abn) // decel limit
		go(`AORS_CMD_ESC_MINUS, 4'h0);
		go(`AORS_CMD_RET_PLUS, 4'hB);
		`CHK("m11 origin", -8, MDL.zero_at) // reversed index
		`CHK("m11 end", -8, MDL.pos) // plus to zero
		limit_stop_method = 1'b0;
		clear_out_on_limit = 1'b1;
		index_count_setting = 4'h0;
		n_erc = 0;
		go(`AORS_CMD_RET_PLUS, 4'hC);
		`CHK("m12 origin", 16, MDL.zero_at) // first index
		`CHK("m12 end", 16, MDL.pos) // stop at index
		`CHK("limit clear out", 2, n_erc) // limit and origin
		finish_test;
	end
endmodule // axis_origin_return_sequencer_test
